// >>> include/rxcal_pkg.sv
// Purpose: Shared constants and types for the receiver setup word bank.
// Assumes: Serial words arrive bit 0 first; 32 bits per word.
// Notes:   Field positions are bit indices inside the 32-bit setup word.
package rxcal_pkg;
   localparam int WORD_W = 32;                          // Serial word width
   // Address field of every serial word
   localparam int ADDR_REG_LSB  = 0;                    // Register select low bit
   localparam int ADDR_BANK_LSB = 3;                    // Bank select low bit
   localparam logic [2:0] REG_CAL   = 3'h2;             // Calibration setup word
   localparam logic [2:0] REG_MIX   = 3'h3;             // Mixer load and filter word
   localparam logic [2:0] REG_BIAS  = 3'h5;             // Bias trim word
   localparam logic [1:0] BANK_SETUP = 2'h1;            // Bank holding these words
   // Calibration word fields
   localparam int CAL_START_POS = 5;                    // Autocal start, self clearing
   localparam int IOFS_LSB      = 6;                    // In-phase offset code
   localparam int QOFS_LSB      = 14;                   // Quadrature offset code
   localparam int DETREF_LSB    = 22;                   // Detector reference current
   localparam int CALSEL_POS    = 24;                   // 1 = automatic calibration
   localparam int DIVSEL_LSB    = 25;                   // Calibration clock divide code
   localparam int CLKSRC_POS    = 28;                   // 1 = internal oscillator
   localparam int OSCTRIM_LSB   = 29;                   // Oscillator trim
   // Mixer load word fields
   localparam int INPHASE_LOAD_SIDE_A_LSB   = 5;                    // In-phase load side A
   localparam int INPHASE_LOAD_SIDE_B_LSB   = 11;                   // In-phase load side B
   localparam int QUAD_LOAD_SIDE_A_LSB   = 17;                   // Quadrature load side A
   localparam int QUAD_LOAD_SIDE_B_LSB   = 23;                   // Quadrature load side B
   localparam int BYPASS_POS    = 29;                   // Filter bypass
   localparam int PEAK_LSB      = 30;                   // Peaking control
   // Bias trim word fields
   localparam int TRIM_LSB      = 5;                    // First of six 2-bit trims
   // Reset values
   localparam logic [7:0] IOFS_RST    = 8'h80;          // Only top bit set
   localparam logic [7:0] QOFS_RST    = 8'h80;          // Only top bit set
   localparam logic [1:0] DETREF_RST  = 2'h3;           // Highest current
   localparam logic       CALSEL_RST  = 1'b1;           // Automatic
   localparam logic [2:0] DIVSEL_RST  = 3'h0;           // Divide by 1
   localparam logic       CLKSRC_RST  = 1'b1;           // Internal oscillator
   localparam logic [2:0] OSCTRIM_RST = 3'h1;           // Low bit set, others clear
   localparam logic [1:0] PEAK_RST    = 2'h1;           // Peaking control default
   localparam logic [1:0] TRIM_RST    = 2'h1;           // Every current trim
   // Divide ratios per code
   localparam logic [14:0] DIV_R0 = 15'h0001;           // 1
   localparam logic [14:0] DIV_R1 = 15'h0008;           // 8
   localparam logic [14:0] DIV_R2 = 15'h0010;           // 16
   localparam logic [14:0] DIV_R3 = 15'h0080;           // 128
   localparam logic [14:0] DIV_R4 = 15'h0100;           // 256
   localparam logic [14:0] DIV_R5 = 15'h0400;           // 1024
   localparam logic [14:0] DIV_R6 = 15'h0800;           // 2048
   localparam logic [14:0] DIV_R7 = 15'h412c;           // 16684

   // Decoded setup fields driven to the analog side
   typedef struct packed {
      logic [7:0] inphase_offset_code;
      logic [7:0] quad_offset_code;
      logic [1:0] detector_ref_current_sel;
      logic       auto_cal_sel;
      logic [2:0] cal_div_code;
      logic       cal_src_osc;
      logic [2:0] osc_trim;
      logic [5:0] inphase_load_side_a;
      logic [5:0] inphase_load_side_b;
      logic [5:0] quad_load_side_a;
      logic [5:0] quad_load_side_b;
      logic       filter_bypass;
      logic [1:0] peaking_ctrl;
      logic [1:0] mixer_transconductance_adj;
      logic [1:0] switch_core_common_mode_adj;
      logic [1:0] local_osc_buffer_current_adj;
      logic [1:0] mixer_out_buffer_current_adj;
      logic [1:0] filter_current_adj;
      logic [1:0] filter_out_buffer_current_adj;
   } rxcal_setup_t;

   // Autocal control states
   typedef enum logic [1:0] {
      RXCAL_IDLE = 2'b01,
      RXCAL_RUN  = 2'b10
   } rxcal_state_t;
endpackage

// >>> verilog/rxcal_setup_regs.sv
// Purpose: Serially loaded calibration, mixer-load and bias-trim setup words.
// Assumes: Serial pins are asynchronous to clk_i; bits sampled on serial clock rise.
// Notes:   Calibration algorithm is outside; it reports completion on cal_done_i.
//          A stored word reaches the field outputs about three clocks after the
//          strobe pin rises: two synchroniser flops, then the store on the decoded edge.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - In-phase offset code bits 6-13, reset 128
// - Quadrature offset code bits 14-21, reset 128
// - Detector reference current bits 22-23, reset 11
// - Bit 24 picks manual or automatic calibration
// - Bits 25-27 pick calibration clock divide ratio
// - Bit 28 picks oscillator or serial clock
// - Bits 29-31 trim internal oscillator frequency
// - Four 6-bit mixer loads, reset zero
// - Filter bypass bit 29, peaking 30-31 reset 01
// - Six 2-bit current trims, bits 5-16, reset 01
// - Bits 0-4 address register and bank
// - Bit 5 starts autocal when bit 24 is set, self clears when done
module rxcal_setup_regs (
   input  wire logic                  clk_i,          // 20 MHz system clock
   input  wire logic                  reset_n_i,      // Async reset, active low
   input  wire logic                  ser_clk_i,      // Serial clock pin
   input  wire logic                  ser_data_i,     // Serial data pin
   input  wire logic                  ser_strobe_i,   // Latch enable pin, rise stores word
   input  wire logic                  osc_clk_i,      // Internal oscillator output
   input  wire logic                  cal_done_i,     // Calibration finished, one-cycle pulse
   output rxcal_pkg::rxcal_setup_t    setup_o,        // Stored setup fields
   output logic                       cal_active_o,   // Autocal start bit state
   output logic                       cal_tick_o      // Divided calibration clock enable
);

   // Divide code to ratio lookup
   function automatic logic [14:0] div_ratio(input logic [2:0] code);
      case (code)
         3'h0:    div_ratio = rxcal_pkg::DIV_R0;
         3'h1:    div_ratio = rxcal_pkg::DIV_R1;
         3'h2:    div_ratio = rxcal_pkg::DIV_R2;
         3'h3:    div_ratio = rxcal_pkg::DIV_R3;
         3'h4:    div_ratio = rxcal_pkg::DIV_R4;
         3'h5:    div_ratio = rxcal_pkg::DIV_R5;
         3'h6:    div_ratio = rxcal_pkg::DIV_R6;
         default: div_ratio = rxcal_pkg::DIV_R7;
      endcase
   endfunction

   logic [3:0]  sync1_reg;                // First stage: sclk, data, strobe, osc
   logic [3:0]  sync2_reg;                // Second stage
   logic        sclk_d_reg;               // Delayed serial clock for edge
   logic        strb_d_reg;               // Delayed strobe for edge
   logic        osc_d_reg;                // Delayed oscillator for edge
   logic [31:0] shift_reg;                // Serial shift register
   logic [31:0] cal_reg;                  // Calibration word, bits 31..6 used
   logic [31:0] mix_reg;                  // Mixer load and filter word
   logic [31:0] bias_reg;                 // Bias trim word
   rxcal_pkg::rxcal_state_t state_reg;    // Autocal state
   rxcal_pkg::rxcal_state_t state_next;   // Autocal next state
   logic [14:0] div_cnt_reg;              // Calibration clock divider count
   logic        tick_reg;                 // Registered divided tick

   // Edge and decode wires. Address bits sit at the bottom of the shifted
   // word once all 32 bits are in; a short word leaves stale lower bits.
   // Edges are one clock wide because each compares against a delayed copy.
   wire         sclk_rise = sync2_reg[0] & ~sclk_d_reg;
   wire         strb_rise = sync2_reg[2] & ~strb_d_reg;
   wire         osc_rise  = sync2_reg[3] & ~osc_d_reg;
   wire [2:0]   wr_reg    = shift_reg[rxcal_pkg::ADDR_REG_LSB +: 3];
   wire [1:0]   wr_bank   = shift_reg[rxcal_pkg::ADDR_BANK_LSB +: 2];
   wire         bank_ok   = (wr_bank == rxcal_pkg::BANK_SETUP);
   wire         wr_cal    = strb_rise & bank_ok & (wr_reg == rxcal_pkg::REG_CAL);
   wire         wr_mix    = strb_rise & bank_ok & (wr_reg == rxcal_pkg::REG_MIX);
   wire         wr_bias   = strb_rise & bank_ok & (wr_reg == rxcal_pkg::REG_BIAS);
   wire         src_edge  = cal_reg[rxcal_pkg::CLKSRC_POS] ? osc_rise : sclk_rise;
   wire [14:0]  ratio     = div_ratio(cal_reg[rxcal_pkg::DIVSEL_LSB +: 3]);
   wire         div_wrap  = (div_cnt_reg >= ratio - 15'h0001);
   wire         start_req = wr_cal & shift_reg[rxcal_pkg::CAL_START_POS]
                            & shift_reg[rxcal_pkg::CALSEL_POS];

   // Pin synchronisers; first stage read only by second
   // Reset to the idle pin levels so no false edge follows reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= {osc_clk_i, ser_strobe_i, ser_data_i, ser_clk_i};
         sync2_reg <= sync1_reg;
      end
   end

   // Edge detection stage
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sclk_d_reg <= 1'b0;
         strb_d_reg <= 1'b0;
         osc_d_reg  <= 1'b0;
      end else begin
         sclk_d_reg <= sync2_reg[0];
         strb_d_reg <= sync2_reg[2];
         osc_d_reg  <= sync2_reg[3];
      end
   end

   // Shift in bit 0 first; after 32 bits, bit 0 sits at the bottom
   // Data is taken in the cycle the serial clock rise is first seen
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_reg <= 32'h0;
      end else if (sclk_rise) begin
         shift_reg <= {sync2_reg[1], shift_reg[31:1]};
      end
   end

   // Calibration word store; address bits are never kept
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cal_reg <= {rxcal_pkg::OSCTRIM_RST, rxcal_pkg::CLKSRC_RST, rxcal_pkg::DIVSEL_RST,
                     rxcal_pkg::CALSEL_RST, rxcal_pkg::DETREF_RST, rxcal_pkg::QOFS_RST,
                     rxcal_pkg::IOFS_RST, 6'h00};
      end else if (wr_cal) begin
         cal_reg <= {shift_reg[31:6], 6'h00};
      end
   end

   // Mixer load and filter word store
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mix_reg <= {rxcal_pkg::PEAK_RST, 30'h0};
      end else if (wr_mix) begin
         mix_reg <= {shift_reg[31:5], 5'h00};
      end
   end

   // Bias trim word store; upper bits unused
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bias_reg <= {15'h0, {6{rxcal_pkg::TRIM_RST}}, 5'h00};
      end else if (wr_bias) begin
         bias_reg <= {15'h0, shift_reg[16:5], 5'h00};
      end
   end

   // Autocal state; a new start wins over a completion in the same cycle.
   // Any other calibration word write stops a run, so the host can abort
   // by rewriting the word with the start bit clear.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rxcal_pkg::RXCAL_IDLE: begin
            if (start_req) begin
               state_next = rxcal_pkg::RXCAL_RUN;
            end
         end
         rxcal_pkg::RXCAL_RUN: begin
            if (start_req) begin
               state_next = rxcal_pkg::RXCAL_RUN;
            end else if (wr_cal || cal_done_i) begin
               state_next = rxcal_pkg::RXCAL_IDLE;
            end
         end
         default: begin
            state_next = rxcal_pkg::RXCAL_IDLE;
         end
      endcase
   end

   // Autocal state register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= rxcal_pkg::RXCAL_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Divide the selected source edge by the programmed ratio.
   // A calibration word write restarts the count, so a ratio lowered
   // mid-count cannot leave the counter beyond its new wrap point.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt_reg <= 15'h0;
         tick_reg    <= 1'b0;
      end else begin
         tick_reg <= src_edge & div_wrap;
         if (wr_cal) begin
            div_cnt_reg <= 15'h0;
         end else if (src_edge) begin
            div_cnt_reg <= div_wrap ? 15'h0 : div_cnt_reg + 15'h0001;
         end
      end
   end

   // Field outputs straight from stored words
   // Unused word bits are never stored, so they cannot leak into a field
   assign setup_o.inphase_offset_code           = cal_reg[rxcal_pkg::IOFS_LSB +: 8];
   assign setup_o.quad_offset_code              = cal_reg[rxcal_pkg::QOFS_LSB +: 8];
   assign setup_o.detector_ref_current_sel      = cal_reg[rxcal_pkg::DETREF_LSB +: 2];
   assign setup_o.auto_cal_sel                  = cal_reg[rxcal_pkg::CALSEL_POS];
   assign setup_o.cal_div_code                  = cal_reg[rxcal_pkg::DIVSEL_LSB +: 3];
   assign setup_o.cal_src_osc                   = cal_reg[rxcal_pkg::CLKSRC_POS];
   assign setup_o.osc_trim                      = cal_reg[rxcal_pkg::OSCTRIM_LSB +: 3];
   assign setup_o.inphase_load_side_a           = mix_reg[rxcal_pkg::INPHASE_LOAD_SIDE_A_LSB +: 6];
   assign setup_o.inphase_load_side_b           = mix_reg[rxcal_pkg::INPHASE_LOAD_SIDE_B_LSB +: 6];
   assign setup_o.quad_load_side_a              = mix_reg[rxcal_pkg::QUAD_LOAD_SIDE_A_LSB +: 6];
   assign setup_o.quad_load_side_b              = mix_reg[rxcal_pkg::QUAD_LOAD_SIDE_B_LSB +: 6];
   assign setup_o.filter_bypass                 = mix_reg[rxcal_pkg::BYPASS_POS];
   assign setup_o.peaking_ctrl                  = mix_reg[rxcal_pkg::PEAK_LSB +: 2];
   assign setup_o.mixer_transconductance_adj    = bias_reg[rxcal_pkg::TRIM_LSB +: 2];
   assign setup_o.switch_core_common_mode_adj   = bias_reg[rxcal_pkg::TRIM_LSB + 2 +: 2];
   assign setup_o.local_osc_buffer_current_adj  = bias_reg[rxcal_pkg::TRIM_LSB + 4 +: 2];
   assign setup_o.mixer_out_buffer_current_adj  = bias_reg[rxcal_pkg::TRIM_LSB + 6 +: 2];
   assign setup_o.filter_current_adj            = bias_reg[rxcal_pkg::TRIM_LSB + 8 +: 2];
   assign setup_o.filter_out_buffer_current_adj = bias_reg[rxcal_pkg::TRIM_LSB + 10 +: 2];
   assign cal_active_o = (state_reg == rxcal_pkg::RXCAL_RUN);
   assign cal_tick_o   = tick_reg;

   // Checks run on the system clock and stay quiet while reset is low.
   // Each load check looks one cycle after a detected strobe rise, when
   // the stored word and so the field outputs hold the shifted bits.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // Strobe rise with the calibration word address
   sequence s_cal_write;
      strb_rise && bank_ok && wr_reg == rxcal_pkg::REG_CAL;
   endsequence

   // Strobe rise with the mixer load word address
   sequence s_mix_write;
      strb_rise && bank_ok && wr_reg == rxcal_pkg::REG_MIX;
   endsequence

   // Strobe rise with the bias trim word address
   sequence s_bias_write;
      strb_rise && bank_ok && wr_reg == rxcal_pkg::REG_BIAS;
   endsequence

   // Calibration word asking for a start in manual mode
   sequence s_manual_start;
      strb_rise && bank_ok && wr_reg == rxcal_pkg::REG_CAL
      && shift_reg[rxcal_pkg::CAL_START_POS] && !shift_reg[rxcal_pkg::CALSEL_POS];
   endsequence

   // Calibration word with the start bit clear
   sequence s_cal_abort;
      strb_rise && bank_ok && wr_reg == rxcal_pkg::REG_CAL && !shift_reg[rxcal_pkg::CAL_START_POS];
   endsequence

   a_ioffset_load: assert property (s_cal_write |=> setup_o.inphase_offset_code == $past(shift_reg[13:6]))
      else $error("in-phase offset code not loaded");
   a_qoffset_load: assert property (s_cal_write |=> setup_o.quad_offset_code == $past(shift_reg[21:14]))
      else $error("quadrature offset code not loaded");
   a_detref_load: assert property (s_cal_write |=> setup_o.detector_ref_current_sel == $past(shift_reg[23:22]))
      else $error("detector reference not loaded");
   a_calsel_osc_trim: assert property (s_cal_write |=>
         {setup_o.osc_trim, setup_o.cal_src_osc, setup_o.cal_div_code, setup_o.auto_cal_sel}
         == $past(shift_reg[31:24]))
      else $error("calibration mode fields not loaded");

   // Divider, clock source selection and oscillator trim load
   a_div_ratio_tick: assert property (tick_reg |->
         $past(src_edge) && $past(div_cnt_reg) == $past(ratio) - 15'h0001)
      else $error("calibration tick at wrong count");
   a_div_one_passes: assert property (setup_o.cal_div_code == 3'h0 && src_edge |=> tick_reg)
      else $error("divide by one dropped an edge");
   a_src_select: assert property (!cal_reg[rxcal_pkg::CLKSRC_POS] && osc_rise && !sclk_rise |=> !tick_reg)
      else $error("oscillator edge used while serial clock selected");
   a_trim_load: assert property (s_cal_write |=> setup_o.osc_trim == $past(shift_reg[31:29]))
      else $error("oscillator trim not loaded");
   a_div_restart: assert property (s_cal_write |=> div_cnt_reg == 15'h0)
      else $error("divider count not restarted by calibration write");

   // Mixer, filter and bias words
   a_mixer_load: assert property (s_mix_write |=>
         {setup_o.inphase_load_side_a, setup_o.quad_load_side_b} == {$past(shift_reg[10:5]),
          $past(shift_reg[28:23])})
      else $error("mixer load fields not loaded");
   a_mixer_inner: assert property (s_mix_write |=>
         {setup_o.inphase_load_side_b, setup_o.quad_load_side_a} == {$past(shift_reg[16:11]),
          $past(shift_reg[22:17])})
      else $error("inner mixer load fields not loaded");
   a_filter_load: assert property (s_mix_write |=>
         {setup_o.peaking_ctrl, setup_o.filter_bypass} == $past(shift_reg[31:29]))
      else $error("filter control not loaded");
   a_bias_load: assert property (s_bias_write |=>
         bias_reg[16:5] == $past(shift_reg[16:5]))
      else $error("bias trims not loaded");

   // Refused addresses leave every stored word alone
   a_unmapped_hold: assert property (strb_rise && !(wr_cal || wr_mix || wr_bias) |=>
         $stable(cal_reg) && $stable(mix_reg) && $stable(bias_reg))
      else $error("unmatched address changed a setup word");

   // Automatic calibration start, completion, refusal and abort
   a_autocal_clears: assert property (cal_active_o && cal_done_i && !wr_cal |=> !cal_active_o)
      else $error("start bit did not clear on completion");
   a_autocal_starts: assert property (start_req |=> cal_active_o[*2] or (cal_active_o ##1 !cal_active_o))
      else $error("start request did not take effect");
   a_manual_no_start: assert property (s_manual_start |=> !cal_active_o)
      else $error("manual mode word started calibration");
   a_abort_clears: assert property (s_cal_abort |=> !cal_active_o)
      else $error("cleared start bit left calibration running");

endmodule

`default_nettype wire

// >>> tb/rxcal_host_model.sv
// Purpose: Host controller model driving the three-wire serial port.
// Assumes: Each serial clock phase lasts four system clocks.
// Notes:   Serial clock idles low between words; released data shows the inverse bit.
`timescale 1ns/1ns
`default_nettype none
module rxcal_host_model (
   input  wire logic clk_i,        // System clock, pacing only
   output logic      ser_clk_o,    // Serial clock, still outside frames
   output logic      ser_data_o,   // Serial data, bit 0 first
   output logic      ser_strobe_o  // Latch enable
);
   // Idle levels from time zero
   initial begin
      ser_clk_o    = 1'b0;
      ser_data_o   = 1'b0;
      ser_strobe_o = 1'b0;
   end
   // Let a number of falling edges pass
   task automatic pause(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Shift a whole word out, address bits first, then pulse the latch enable
   task automatic send_word(input logic [31:0] w);
      for (int i = 0; i < 32; i++) begin
         ser_data_o = w[i];
         pause(4);
         ser_clk_o = 1'b1;
         pause(4);
         ser_clk_o = 1'b0;
      end
      ser_data_o = ~ser_data_o;  // Released line must not keep the last bit
      pause(4);
      ser_strobe_o = 1'b1;
      pause(4);
      ser_strobe_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_rx_cal_trim_setup_regs.sv
// Purpose: Self-checking bench for the receiver setup word bank.
// Assumes: Host model shifts words; bench drives reset, oscillator and done pulse.
// Notes:   Expected fields are rebuilt here from the bit map, not from the design.
`timescale 1ns/1ns
`default_nettype none
module tb_rx_cal_trim_setup_regs;
   typedef struct packed {logic [31:0] word; logic stored;} rxtb_row_t;  // Word and whether it lands
   logic                    clk, reset_n, osc_clk, cal_done;  // Bench driven inputs
   wire logic               ser_clk, ser_data, ser_strobe;    // Host model pins
   rxcal_pkg::rxcal_setup_t setup, exp_s, rst_s;              // Design fields, model, reset image
   logic                    cal_active, cal_tick;             // Autocal state and tick
   int                      mismatches, compares, ticks, oscs;
   logic [31:0]             w;
   // Ordinary cases: cal, mixer, bias words, then refused addresses, then host defaults
   rxtb_row_t rows [9] = '{
      '{{3'h6, 1'b0, 3'h7, 1'b0, 2'h0, 8'ha5, 8'h5a, 1'b0, 5'h0a}, 1'b1},
      '{{2'h2, 1'b1, 6'h2a, 6'h15, 6'h3f, 6'h01, 5'h0b}, 1'b1},
      '{{15'h7fff, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h0, 5'h0d}, 1'b1},
      '{{27'h7ffffff, 5'h0c}, 1'b0}, '{{27'h0, 5'h12}, 1'b0}, '{{27'h0, 5'h02}, 1'b0},
      '{{27'h0, 5'h09}, 1'b0}, '{{27'h7ffffff, 5'h0f}, 1'b0},
      '{{2'h1, 1'b0, 24'h0, 5'h0b}, 1'b1}};
   rxcal_host_model HOST (.clk_i(clk), .ser_clk_o(ser_clk), .ser_data_o(ser_data), .ser_strobe_o(ser_strobe));
   rxcal_setup_regs DUT (.clk_i(clk), .reset_n_i(reset_n), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
      .ser_strobe_i(ser_strobe), .osc_clk_i(osc_clk), .cal_done_i(cal_done), .setup_o(setup),
      .cal_active_o(cal_active), .cal_tick_o(cal_tick));
   // System clock and an unrelated oscillator
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      osc_clk = 1'b0;
      forever #170 osc_clk = ~osc_clk;
   end
   // Count divided ticks and oscillator rises
   always @(posedge clk) begin
      if (cal_tick === 1'b1) ticks++;
   end
   always @(posedge osc_clk) oscs++;
   // Expected fields after a stored word
   function automatic rxcal_pkg::rxcal_setup_t apply(input rxcal_pkg::rxcal_setup_t s, input logic [31:0] v);
      case (v[2:0])
         3'h2: begin
            {s.osc_trim, s.cal_src_osc, s.cal_div_code, s.auto_cal_sel} = v[31:24];
            {s.detector_ref_current_sel, s.quad_offset_code, s.inphase_offset_code} = v[23:6];
         end
         3'h3: begin
            {s.peaking_ctrl, s.filter_bypass, s.quad_load_side_b, s.quad_load_side_a} = v[31:17];
            {s.inphase_load_side_b, s.inphase_load_side_a} = v[16:5];
         end
         default: begin
            {s.filter_out_buffer_current_adj, s.filter_current_adj, s.mixer_out_buffer_current_adj} = v[16:11];
            {s.local_osc_buffer_current_adj, s.switch_core_common_mode_adj, s.mixer_transconductance_adj} = v[10:5];
         end
      endcase
      return s;
   endfunction
   // Compare all setup fields
   task automatic check_setup(input string what);
      compares++;
      if (setup !== exp_s) begin
         mismatches++;
         $display("[ERR] %0t %s fields got %h want %h", $time, what, setup, exp_s);
      end
   endtask
   // Compare one flag or condition
   task automatic check_bit(input logic got, input logic want, input string what);
      compares++;
      if (got !== want) begin
         mismatches++;
         $display("[ERR] %0t %s got %b want %b", $time, what, got, want);
      end
   endtask
   // Send a word and let the store settle
   task automatic write_word(input logic [31:0] v);
      HOST.send_word(v);
      repeat (2) @(negedge clk);
   endtask
   // Counts and verdict, then stop
   task automatic results;
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      $display("[ERR] %0t run limit reached", $time);
      results();
   end
   // Main sequence
   initial begin
      reset_n = 1'b0;
      cal_done = 1'b0;
      {mismatches, compares, ticks, oscs} = '0;
      rst_s = '{8'h80, 8'h80, 2'h3, 1'b1, 3'h0, 1'b1, 3'h1, 6'h0, 6'h0, 6'h0, 6'h0, 1'b0, 2'h1,
                2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
      exp_s = rst_s;
      repeat (5) @(negedge clk);
      check_setup("reset");
      check_bit(cal_active, 1'b0, "reset active");
      reset_n = 1'b1;
      $display("test reset done");
      foreach (rows[i]) begin
         write_word(rows[i].word);
         if (rows[i].stored) exp_s = apply(exp_s, rows[i].word);
         check_setup("row");
      end
      $display("test table done");
      // Automatic start, done pulse, manual refusal, abort, mid-run reset
      w = {3'h6, 1'b1, 3'h0, 1'b1, 2'h3, 8'h80, 8'h80, 1'b1, 5'h0a};
      write_word(w);
      exp_s = apply(exp_s, w);
      check_bit(cal_active, 1'b1, "start");
      cal_done = 1'b1;
      @(negedge clk);
      cal_done = 1'b0;
      @(negedge clk);
      check_bit(cal_active, 1'b0, "done");
      write_word({w[31:25], 1'b0, w[23:0]});
      check_bit(cal_active, 1'b0, "manual start");
      write_word(w);
      write_word({w[31:6], 1'b0, w[4:0]});
      check_bit(cal_active, 1'b0, "abort");
      write_word(w);
      reset_n = 1'b0;
      @(negedge clk);
      exp_s = rst_s;
      check_setup("mid reset");
      check_bit(cal_active, 1'b0, "mid reset active");
      reset_n = 1'b1;
      $display("test autocal done");
      // Oscillator source at divide by one
      repeat (2) @(negedge clk);
      {ticks, oscs} = '0;
      repeat (400) @(negedge clk);
      check_bit((ticks - oscs <= 2) && (oscs - ticks <= 2), 1'b1, "osc ticks");
      // Serial clock source at divide codes 0, 1 and 2
      w = {3'h6, 1'b0, 3'h0, 1'b1, 2'h3, 8'h80, 8'h80, 1'b0, 5'h0a};
      write_word(w);
      ticks = 0;
      write_word({w[31:28], 3'h1, w[24:0]});
      check_bit(ticks == 32, 1'b1, "serial ticks div 1");
      ticks = 0;
      write_word({w[31:28], 3'h1, w[24:0]});
      check_bit(ticks == 4, 1'b1, "serial ticks div 8");
      ticks = 0;
      write_word({w[31:28], 3'h2, w[24:0]});
      check_bit(ticks == 4, 1'b1, "serial ticks div 8 again");
      ticks = 0;
      write_word({w[31:28], 3'h2, w[24:0]});
      check_bit(ticks == 2, 1'b1, "serial ticks div 16");
      $display("test cal clock done");
      results();
   end
endmodule
`default_nettype wire
